// ===== tb/flash_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
	output var logic       sclk_o,
	output var logic       cs_n_o,
	output var logic [3:0] io_o,
	input  wire logic      so_i
);
	logic [7:0]  dat [0:511];
	logic [15:0] rd;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		io_o = 4'hA;
	end
	// Data changes while the clock is low; the reply bit is taken just before the rise.
	task automatic pulse(input logic [3:0] v);
		io_o = v;
		#200 rd = {rd[14:0], so_i};
		sclk_o = 1'b1;
		#200 sclk_o = 1'b0;
	endtask
	task automatic xfer(input logic [31:0] hdr, input int hb, input int nb, input bit quad);
		int i;
		cs_n_o = 1'b0;
		for (i = 0; i < hb; i++) pulse({3'h0, hdr[31-i]});
		for (i = 0; i < nb * (quad ? 2 : 8); i++)
			pulse(quad ? (i[0] ? dat[i/2][3:0] : dat[i/2][7:4]) : {3'h0, dat[i/8][7-i%8]});
		#200 cs_n_o = 1'b1;
		io_o = ~io_o;
		#600;
	endtask
endmodule
`default_nettype wire

// ===== tb/flash_program_erase_control_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module flash_pec_monitor (
	input wire logic        core_clk_i,
	input wire logic        srst_i,
	input wire logic        cs_n_i,
	input wire logic [3:0]  io_oe_o,
	input wire logic        write_enable_latch_o,
	input wire logic        write_in_progress_o,
	input wire logic        erase_error_o,
	input wire logic        protection_error_flag_o,
	input wire logic        mem_wr_valid_o,
	input wire logic [21:0] mem_wr_addr_o,
	input wire logic [7:0]  mem_wr_data_o,
	input wire logic        mem_wr_ready_i,
	input wire logic        erase_req_o,
	input wire logic [21:0] erase_base_o,
	input wire logic [1:0]  erase_size_o,
	input wire logic        erase_ack_i
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	sequence s_ack;
		erase_req_o && erase_ack_i;
	endsequence
	sequence s_released;
		!erase_req_o && !write_in_progress_o && !write_enable_latch_o;
	endsequence
	a_erase_done: assert property (s_ack |=> s_released)
		else $error("erase end not released");
	a_erase_hold: assert property (erase_req_o && !erase_ack_i |=>
		erase_req_o && $stable({erase_size_o, erase_base_o}))
		else $error("erase request changed");
	a_erase_busy: assert property (erase_req_o |-> write_in_progress_o)
		else $error("erase without busy");
	a_erase_align: assert property (erase_req_o |-> (erase_size_o == 2'h0 ? erase_base_o[11:0] == 12'h000 :
		erase_size_o == 2'h1 ? erase_base_o[14:0] == 15'h0000 : erase_base_o[15:0] == 16'h0000))
		else $error("erase base not aligned");
	a_write_busy: assert property (mem_wr_valid_o |-> write_in_progress_o)
		else $error("array write without busy");
	a_write_hold: assert property (mem_wr_valid_o && !mem_wr_ready_i |=>
		mem_wr_valid_o && $stable({mem_wr_addr_o, mem_wr_data_o}))
		else $error("array write dropped");
	a_start_after: assert property ($rose(write_in_progress_o) |-> cs_n_i && write_enable_latch_o)
		else $error("cycle started wrongly");
	a_latch_idle: assert property ($rose(write_enable_latch_o) |-> !write_in_progress_o)
		else $error("latch set while busy");
	a_error_pair: assert property ($rose(erase_error_o) |-> protection_error_flag_o && !erase_req_o)
		else $error("error flags not paired");
	a_drive_sel: assert property ($rose(io_oe_o[1]) |-> !cs_n_i && io_oe_o[3:2] == 2'h0 && !io_oe_o[0])
		else $error("output driven unselected");
	a_wip_clear: assert property ($fell(write_in_progress_o) |-> !write_enable_latch_o && !mem_wr_valid_o)
		else $error("busy end not clean");
endmodule
bind flash_program_erase_control flash_pec_monitor flash_pec_monitor_inst (.core_clk_i, .srst_i, .cs_n_i, .io_oe_o,
	.write_enable_latch_o, .write_in_progress_o, .erase_error_o, .protection_error_flag_o, .mem_wr_valid_o,
	.mem_wr_addr_o, .mem_wr_data_o, .mem_wr_ready_i, .erase_req_o, .erase_base_o, .erase_size_o, .erase_ack_i);
`default_nettype wire

// ===== tb/flash_program_erase_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module flash_program_erase_control_test;
	logic        core_clk_i, srst_i, sclk_i, cs_n_i, quad_enable_i, err_clear_i, mem_wr_ready_i, erase_ack_i, hold;
	logic [3:0]  block_protect_bits_i, io_o, io_oe_o, h_io;
	logic        write_enable_latch_o, write_in_progress_o, erase_error_o, protection_error_flag_o;
	logic        mem_wr_valid_o, erase_req_o;
	logic [21:0] mem_wr_addr_o, erase_base_o, a;
	logic [7:0]  mem_wr_data_o;
	logic [1:0]  erase_size_o;
	logic [29:0] wq [$];
	logic [23:0] eq [$];
	logic [7:0]  exp_pg [0:255];
	logic [7:0]  eop [0:5] = '{8'hD7, 8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
	logic [21:0] msk [0:3] = '{22'h3FF000, 22'h3F8000, 22'h3F0000, 22'h000000};
	int          errors, cmp_count, ack_cnt, i, sz;
	wire  [3:0]  io_i = {h_io[3:2], io_oe_o[1] ? io_o[1] : h_io[1], h_io[0]};
	flash_program_erase_control flash_program_erase_control_inst (.core_clk_i, .srst_i, .sclk_i, .cs_n_i, .io_i,
		.io_o, .io_oe_o, .block_protect_bits_i, .quad_enable_i, .err_clear_i, .write_enable_latch_o,
		.write_in_progress_o, .erase_error_o, .protection_error_flag_o, .mem_wr_valid_o, .mem_wr_addr_o,
		.mem_wr_data_o, .mem_wr_ready_i, .erase_req_o, .erase_base_o, .erase_size_o, .erase_ack_i);
	flash_host_model flash_host_model_inst (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .io_o(h_io), .so_i(io_i[1]));
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	task automatic chk_val(input string n, input logic [29:0] e, input logic [29:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic end_of_test;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// Results are matched in order of appearance; an empty queue expects nothing at all.
	always @(posedge core_clk_i) begin
		if (mem_wr_valid_o && mem_wr_ready_i)
			chk_val("array write", wq.size() ? wq.pop_front() : 30'hX, {mem_wr_addr_o, mem_wr_data_o});
		if (erase_req_o && !erase_ack_i) ack_cnt++;
		else ack_cnt = 0;
		if (ack_cnt == 20)
			chk_val("erase", eq.size() ? {6'h00, eq.pop_front()} : 30'hX, {6'h00, erase_size_o, erase_base_o});
		#1;
		erase_ack_i = (ack_cnt == 20);
		mem_wr_ready_i = !hold && ($urandom % 3 != 0);
	end
	task automatic op(input logic [31:0] h, input int hb, input int nb = 0, input bit q = 0);
		flash_host_model_inst.xfer(h, hb, nb, q);
		// Realign so that every later stimulus changes just after a clock edge.
		@(posedge core_clk_i) #1;
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (n < 4000 && (write_in_progress_o !== 1'b0 || wq.size() || eq.size()));
		#1;
		if (n == 4000) begin
			errors++;
			end_of_test();
		end
	endtask
	task automatic prog(input logic [7:0] opc, input logic [21:0] ad, input int nb, input bit we, input bit ok);
		logic [255:0] hit;
		hit = '0;
		for (i = 0; i < nb; i++) begin
			flash_host_model_inst.dat[i] = 8'($urandom);
			exp_pg[8'(ad[7:0] + i)] = flash_host_model_inst.dat[i];
			hit[8'(ad[7:0] + i)] = 1'b1;
		end
		for (i = 0; i < 256; i++) if (ok && hit[i]) wq.push_back({ad[21:8], i[7:0], exp_pg[i]});
		if (we) op({8'h06, 24'h0}, 8);
		op({opc, 2'h0, ad}, 32, nb, opc != 8'h02);
		if (!hold) wait_idle();
	endtask
	initial begin
		void'($urandom(32'h76611514));
		{hold, quad_enable_i, err_clear_i} = '0;
		srst_i = 1'b1;
		block_protect_bits_i = 4'h0;
		repeat (6) @(posedge core_clk_i);
		#1 srst_i = 1'b0;
		chk_val("latch", 30'h0, write_enable_latch_o);
		repeat (3) @(posedge core_clk_i) #1;
		prog(8'h02, 22'h001234, 1, 0, 0);
		prog(8'h02, 22'h0AB0FE, 300, 1, 1);
		chk_val("latch", 30'h0, write_enable_latch_o);
		prog(8'h02, 22'h0AB0FF, 3, 1, 1);
		quad_enable_i = 1'b1;
		prog(8'h32, 22'h1234F0, 5, 1, 1);
		prog(8'h38, 22'h222210, 2, 1, 1);
		quad_enable_i = 1'b0;
		prog(8'h38, 22'h222210, 2, 1, 0);
		block_protect_bits_i = 4'h7;
		prog(8'h02, 22'h000000, 4, 1, 0);
		op({8'h05, 24'h0}, 16);
		chk_val("status", 30'h1E, flash_host_model_inst.rd[7:0]);
		block_protect_bits_i = 4'h1;
		op({8'hC7, 24'h0}, 8);
		chk_val("error flags", 30'h3, {erase_error_o, protection_error_flag_o});
		err_clear_i = 1'b1;
		@(posedge core_clk_i) #1 err_clear_i = 1'b0;
		chk_val("error flags", 30'h0, {erase_error_o, protection_error_flag_o});
		block_protect_bits_i = 4'h0;
		for (int k = 0; k < 6; k++) begin
			sz = k < 2 ? 0 : (k > 4 ? 3 : k - 1);
			a = 22'($urandom);
			eq.push_back({sz[1:0], a & msk[sz]});
			op({8'h06, 24'h0}, 8);
			chk_val("latch", 30'h1, write_enable_latch_o);
			op({eop[k], 2'h0, a}, sz == 3 ? 8 : 32);
			chk_val("busy", 30'h1, write_in_progress_o);
			wait_idle();
			chk_val("latch", 30'h0, write_enable_latch_o);
		end
		hold = 1'b1;
		prog(8'h02, 22'h3000FF, 2, 1, 1);
		op({8'h05, 24'h0}, 16);
		chk_val("status", 30'h03, flash_host_model_inst.rd[7:0]);
		op({8'h20, 24'h001000}, 32);
		hold = 1'b0;
		wait_idle();
		chk_val("latch", 30'h0, write_enable_latch_o);
		end_of_test();
	end
endmodule
`default_nettype wire

// ===== verilog/flash_pec_defs.vh
`ifndef FLASH_PEC_DEFS_VH
`define FLASH_PEC_DEFS_VH
`define OP_PAGE_PROGRAM   8'h02
`define OP_QUAD_PROG_A    8'h32
`define OP_QUAD_PROG_B    8'h38
`define OP_SECTOR_ERASE_A 8'hD7
`define OP_SECTOR_ERASE_B 8'h20
`define OP_HALF_BLOCK     8'h52
`define OP_FULL_BLOCK     8'hD8
`define OP_CHIP_ERASE_A   8'hC7
`define OP_CHIP_ERASE_B   8'h60
`define OP_WRITE_ENABLE   8'h06
`define OP_STATUS_READ    8'h05
`define OPCODE_LAST_BIT   6'h07
`define ADDR_LAST_BIT     6'h1F
`define OPCODE_ONLY_BITS  6'h08
`define OPCODE_ADDR_BITS  6'h20
`define BITCNT_MAX        6'h3F
`define ERASE_SECTOR      2'h0
`define ERASE_HALF_BLOCK  2'h1
`define ERASE_FULL_BLOCK  2'h2
`define ERASE_CHIP        2'h3
`define SECTOR_MASK       22'h3FF000
`define HALF_BLOCK_MASK   22'h3F8000
`define FULL_BLOCK_MASK   22'h3F0000
`define PROT_ALL_LEVEL    4'h7
`define PROT_BLOCKS_TOTAL 7'h40
`define SERIAL_BYTE_LAST  3'h7
`define QUAD_BYTE_LAST    3'h4
`define RESET_BYTE_IDX    8'h00
`define LAST_BYTE_IDX     8'hFF
`endif

// ===== verilog/flash_program_erase_control.v
// What this block does
// - Page program opcode writes 1..256 bytes.
// - Program into protected page is ignored.
// - Cycle starts at chip select rise only.
// - While busy, only status read accepted.
// - Busy flag one during cycle, else zero.
// - Over 256 bytes wrap; last 256 kept.
// - Start anywhere; unsent page bytes untouched.
// - Program only clears bits; erase sets.
// - Erase sets region ones; uniform sectors, blocks.
// - Latch clears when any write completes.
// - Half and full block erase opcodes.
// - Chip erase needs latch, no address.
// - Chip erase refused when protected; flags set.
// - Write enable opcode sets the latch.
// - Latch comes out of reset cleared.
// - Every write operation requires the latch.
// - Status read returns status, allowed while busy.
// - Bits sampled on serial clock rising edge.
`timescale 1ns/10ps
`default_nettype none
`include "flash_pec_defs.vh"

module pec_fifo #(
	parameter WIDTH = 30,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk_i,
	input  wire             srst_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	input  wire [WIDTH-1:0] in_data_i,
	output reg              out_valid_o,
	input  wire             out_ready_i,
	output reg  [WIDTH-1:0] out_data_o,
	output wire             busy_o
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wp_r;
	reg [AW-1:0]    rp_r;
	reg [AW:0]      cnt_r;
	wire            push;
	wire            pop;

	assign in_ready_o = (cnt_r < DEPTH[AW:0]);
	assign push       = in_valid_i & in_ready_o;
	// The output stage is a register so the consumer never sees array read logic.
	assign pop        = (cnt_r != {(AW+1){1'b0}}) & (~out_valid_o | out_ready_i);
	assign busy_o     = out_valid_o | (cnt_r != {(AW+1){1'b0}});

	always @(posedge clk_i) begin
		if (push) begin
			mem[wp_r] <= in_data_i;
		end
		if (srst_i) begin
			wp_r        <= {AW{1'b0}};
			rp_r        <= {AW{1'b0}};
			cnt_r       <= {(AW+1){1'b0}};
			out_valid_o <= 1'b0;
			out_data_o  <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rp_r       <= rp_r + {{(AW-1){1'b0}}, 1'b1};
				out_data_o <= mem[rp_r];
			end
			if (pop) begin
				out_valid_o <= 1'b1;
			end else if (out_ready_i) begin
				out_valid_o <= 1'b0;
			end
			cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule

module flash_program_erase_control #(
	parameter FIFO_DEPTH = 16,
	parameter FIFO_AW    = 4
) (
	input  wire        core_clk_i,
	input  wire        srst_i,
	input  wire        sclk_i,
	input  wire        cs_n_i,
	input  wire [3:0]  io_i,
	output reg  [3:0]  io_o,
	output reg  [3:0]  io_oe_o,
	input  wire [3:0]  block_protect_bits_i,
	input  wire        quad_enable_i,
	input  wire        err_clear_i,
	output reg         write_enable_latch_o,
	output reg         write_in_progress_o,
	output reg         erase_error_o,
	output reg         protection_error_flag_o,
	output wire        mem_wr_valid_o,
	output wire [21:0] mem_wr_addr_o,
	output wire [7:0]  mem_wr_data_o,
	input  wire        mem_wr_ready_i,
	output reg         erase_req_o,
	output reg  [21:0] erase_base_o,
	output reg  [1:0]  erase_size_o,
	input  wire        erase_ack_i
);
	localparam PH_OP   = 3'h0;
	localparam PH_ADDR = 3'h1;
	localparam PH_DATA = 3'h2;
	localparam PH_STAT = 3'h3;
	localparam PH_IGN  = 3'h4;
	localparam SQ_IDLE  = 2'h0;
	localparam SQ_LOAD  = 2'h1;
	localparam SQ_DRAIN = 2'h2;
	localparam SQ_ERASE = 2'h3;

	reg [2:0]   sclk_s_r;
	reg [2:0]   cs_s_r;
	reg [3:0]   io_s1_r;
	reg [3:0]   io_s2_r;
	reg [2:0]   phase_r;
	reg [7:0]   op_r;
	reg [5:0]   bitcnt_r;
	reg [23:0]  addr_r;
	reg [7:0]   shf_r;
	reg [2:0]   bcnt_r;
	reg [7:0]   wptr_r;
	reg         got_data_r;
	reg [2:0]   statbit_r;
	reg [7:0]   page_buf [0:255];
	reg [255:0] page_vld_r;
	reg [1:0]   sq_r;
	reg [7:0]   idx_r;
	reg [13:0]  page_r;

	wire       sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
	wire       sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
	wire       cs_low    = ~cs_s_r[1];
	wire       frame_end = cs_s_r[1] & ~cs_s_r[2];
	wire [7:0] op_nxt    = {op_r[6:0], io_s2_r[0]};
	wire [23:0] addr_nxt = {addr_r[22:0], io_s2_r[0]};
	wire       busy      = (sq_r != SQ_IDLE);
	wire       is_quad   = (op_r == `OP_QUAD_PROG_A) | (op_r == `OP_QUAD_PROG_B);
	wire       is_prog   = (op_r == `OP_PAGE_PROGRAM) | is_quad;
	wire       is_sect   = (op_r == `OP_SECTOR_ERASE_A) | (op_r == `OP_SECTOR_ERASE_B);
	wire       is_chip   = (op_r == `OP_CHIP_ERASE_A) | (op_r == `OP_CHIP_ERASE_B);
	wire       is_blk    = (op_r == `OP_HALF_BLOCK) | (op_r == `OP_FULL_BLOCK) | is_sect;
	wire [7:0] sh_in     = is_quad ? {shf_r[3:0], io_s2_r} : {shf_r[6:0], io_s2_r[0]};
	wire       byte_done = is_quad ? (bcnt_r == `QUAD_BYTE_LAST) : (bcnt_r == `SERIAL_BYTE_LAST);
	wire [7:0] status    = {1'b0, quad_enable_i, block_protect_bits_i, write_enable_latch_o, busy};
	wire [21:0] erase_at = (op_r == `OP_HALF_BLOCK) ? (addr_r[21:0] & `HALF_BLOCK_MASK) :
	                       (op_r == `OP_FULL_BLOCK) ? (addr_r[21:0] & `FULL_BLOCK_MASK) :
	                       (addr_r[21:0] & `SECTOR_MASK);
	wire       fifo_in_valid = (sq_r == SQ_LOAD) & page_vld_r[idx_r];
	wire       fifo_in_ready;
	wire       fifo_busy;
	wire       prog_ok = is_prog & (phase_r == PH_DATA) & got_data_r & (bcnt_r == 3'h0) &
	                     (~is_quad | quad_enable_i) & write_enable_latch_o;

	// Protection covers the top 64 Kbyte blocks; each level doubles the span.
	function prot;
		input [3:0] bp;
		input [5:0] blk;
		reg   [6:0] lim;
		begin
			lim  = `PROT_BLOCKS_TOTAL - (7'h01 << (bp - 4'h1));
			prot = (bp >= `PROT_ALL_LEVEL) | ((bp != 4'h0) & ({1'b0, blk} >= lim));
		end
	endfunction

	always @(posedge core_clk_i) begin
		if (srst_i) begin
			sclk_s_r <= 3'h0;
			cs_s_r   <= 3'h7;
			io_s1_r  <= 4'h0;
			io_s2_r  <= 4'h0;
		end else begin
			sclk_s_r <= {sclk_s_r[1:0], sclk_i};
			cs_s_r   <= {cs_s_r[1:0], cs_n_i};
			io_s1_r  <= io_i;
			io_s2_r  <= io_s1_r;
		end
	end

	always @(posedge core_clk_i) begin
		if (~srst_i & cs_low & sclk_rise & (phase_r == PH_DATA) & byte_done) begin
			page_buf[wptr_r] <= sh_in;
		end
	end

	always @(posedge core_clk_i) begin
		if (srst_i) begin
			phase_r    <= PH_OP;
			op_r       <= 8'h00;
			bitcnt_r   <= 6'h00;
			addr_r     <= 24'h000000;
			shf_r      <= 8'h00;
			bcnt_r     <= 3'h0;
			wptr_r     <= `RESET_BYTE_IDX;
			got_data_r <= 1'b0;
			statbit_r  <= 3'h0;
			page_vld_r <= {256{1'b0}};
			io_o       <= 4'h0;
			io_oe_o    <= 4'h0;
		end else if (~cs_low) begin
			phase_r  <= PH_OP;
			bitcnt_r <= 6'h00;
			io_oe_o  <= 4'h0;
		end else begin
			if (sclk_rise) begin
				if ((phase_r != PH_DATA) & (bitcnt_r != `BITCNT_MAX)) begin
					bitcnt_r <= bitcnt_r + 6'h01;
				end
				case (phase_r)
					PH_OP: begin
						op_r <= op_nxt;
						if (bitcnt_r == 6'h00) begin
							got_data_r <= 1'b0;
						end
						if (bitcnt_r == `OPCODE_LAST_BIT) begin
							statbit_r <= 3'h0;
							if (op_nxt == `OP_STATUS_READ) begin
								phase_r <= PH_STAT;
							end else if (busy) begin
								phase_r <= PH_IGN;
							end else if ((op_nxt == `OP_PAGE_PROGRAM) | (op_nxt == `OP_QUAD_PROG_A) |
							             (op_nxt == `OP_QUAD_PROG_B)) begin
								phase_r    <= PH_ADDR;
								page_vld_r <= {256{1'b0}};
							end else if ((op_nxt == `OP_SECTOR_ERASE_A) | (op_nxt == `OP_SECTOR_ERASE_B) |
							             (op_nxt == `OP_HALF_BLOCK) | (op_nxt == `OP_FULL_BLOCK)) begin
								phase_r <= PH_ADDR;
							end else begin
								phase_r <= PH_IGN;
							end
						end
					end
					PH_ADDR: begin
						addr_r <= addr_nxt;
						if (bitcnt_r == `ADDR_LAST_BIT) begin
							phase_r <= is_prog ? PH_DATA : PH_IGN;
							wptr_r  <= addr_nxt[7:0];
							bcnt_r  <= 3'h0;
						end
					end
					PH_DATA: begin
						shf_r <= sh_in;
						if (byte_done) begin
							page_vld_r[wptr_r] <= 1'b1;
							wptr_r             <= wptr_r + 8'h01;
							got_data_r         <= 1'b1;
							bcnt_r             <= 3'h0;
						end else begin
							bcnt_r <= bcnt_r + (is_quad ? 3'h4 : 3'h1);
						end
					end
					default: begin
					end
				endcase
			end
			if (sclk_fall & (phase_r == PH_STAT)) begin
				io_o[1]    <= status[3'h7 - statbit_r];
				io_oe_o[1] <= 1'b1;
				statbit_r  <= statbit_r + 3'h1;
			end
		end
	end

	pec_fifo #(
		.WIDTH (30),
		.DEPTH (FIFO_DEPTH),
		.AW    (FIFO_AW)
	) u_fifo (
		.clk_i       (core_clk_i),
		.srst_i      (srst_i),
		.in_valid_i  (fifo_in_valid),
		.in_ready_o  (fifo_in_ready),
		.in_data_i   ({page_r, idx_r, page_buf[idx_r]}),
		.out_valid_o (mem_wr_valid_o),
		.out_ready_i (mem_wr_ready_i),
		.out_data_o  ({mem_wr_addr_o, mem_wr_data_o}),
		.busy_o      (fifo_busy)
	);

	always @(posedge core_clk_i) begin
		if (srst_i) begin
			sq_r                    <= SQ_IDLE;
			idx_r                   <= `RESET_BYTE_IDX;
			page_r                  <= 14'h0000;
			write_enable_latch_o    <= 1'b0;
			write_in_progress_o     <= 1'b0;
			erase_error_o           <= 1'b0;
			protection_error_flag_o <= 1'b0;
			erase_req_o             <= 1'b0;
			erase_base_o            <= 22'h000000;
			erase_size_o            <= `ERASE_SECTOR;
		end else begin
			// A refusal in the same cycle as a clear keeps the flags set.
			if (err_clear_i) begin
				erase_error_o           <= 1'b0;
				protection_error_flag_o <= 1'b0;
			end
			case (sq_r)
				SQ_IDLE: begin
					if (frame_end) begin
						if ((op_r == `OP_WRITE_ENABLE) & (bitcnt_r == `OPCODE_ONLY_BITS)) begin
							write_enable_latch_o <= 1'b1;
						end else if (prog_ok & ~prot(block_protect_bits_i, addr_r[21:16])) begin
							sq_r                <= SQ_LOAD;
							idx_r               <= `RESET_BYTE_IDX;
							page_r              <= addr_r[21:8];
							write_in_progress_o <= 1'b1;
						end else if (is_blk & (bitcnt_r == `OPCODE_ADDR_BITS) & write_enable_latch_o &
						             ~prot(block_protect_bits_i, addr_r[21:16])) begin
							sq_r                <= SQ_ERASE;
							erase_req_o         <= 1'b1;
							erase_base_o        <= erase_at;
							erase_size_o        <= is_sect ? `ERASE_SECTOR :
							                       (op_r == `OP_HALF_BLOCK) ? `ERASE_HALF_BLOCK : `ERASE_FULL_BLOCK;
							write_in_progress_o <= 1'b1;
						end else if (is_chip & (bitcnt_r == `OPCODE_ONLY_BITS) & write_enable_latch_o) begin
							if (block_protect_bits_i != 4'h0) begin
								erase_error_o           <= 1'b1;
								protection_error_flag_o <= 1'b1;
							end else begin
								sq_r                <= SQ_ERASE;
								erase_req_o         <= 1'b1;
								erase_base_o        <= 22'h000000;
								erase_size_o        <= `ERASE_CHIP;
								write_in_progress_o <= 1'b1;
							end
						end
					end
				end
				SQ_LOAD: begin
					// Only supplied bytes are pushed; the array ANDs them in, clearing bits only.
					if (~page_vld_r[idx_r] | fifo_in_ready) begin
						idx_r <= idx_r + 8'h01;
						if (idx_r == `LAST_BYTE_IDX) begin
							sq_r <= SQ_DRAIN;
						end
					end
				end
				SQ_DRAIN: begin
					if (~fifo_busy) begin
						sq_r                 <= SQ_IDLE;
						write_in_progress_o  <= 1'b0;
						write_enable_latch_o <= 1'b0;
					end
				end
				SQ_ERASE: begin
					if (erase_ack_i) begin
						sq_r                 <= SQ_IDLE;
						erase_req_o          <= 1'b0;
						write_in_progress_o  <= 1'b0;
						write_enable_latch_o <= 1'b0;
					end
				end
				default: begin
					sq_r <= SQ_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire
